// File: hdl/cmb_regs.vh
// Purpose: constants for the message buffer handler
// Assumes: plain register port, 32-bit data, byte addresses
// Notes:   buffer n occupies a 16-byte block at n*16
`ifndef CMB_REGS_VH
`define CMB_REGS_VH
`define CMB_NBUF          16
`define CMB_BUF_SHIFT     4
`define CMB_OFS_CS        4'h0
`define CMB_OFS_IDU       4'h4
`define CMB_OFS_IDL       4'h8
`define CMB_OFS_DATA      4'hC
`define CMB_ADDR_FLAGS    12'h100
`define CMB_ADDR_TIMER    12'h104
`define CMB_ADDR_STATUS   12'h108
`define CMB_CODE_RX_INACT 4'h0
`define CMB_CODE_RX_EMPTY 4'h4
`define CMB_CODE_RX_FULL  4'h2
`define CMB_CODE_RX_OVRN  4'h6
`define CMB_CODE_TX_INACT 4'h8
`define CMB_CODE_TX_ONCE  4'hC
`define CMB_CODE_TX_RESP  4'hA
`define CMB_BUSY_BIT      0
`define CMB_CS_CODE_LSB   24
`define CMB_CS_TS_LSB     8
`define CMB_CS_RTR_BIT    4
`define CMB_COPY_CYCLES   4'h3
`define CMB_OVL_EOF_BIT   4'h6
`define CMB_OVL_DLM_BIT   4'h7
`endif

// File: hdl/cmb_match.v
// Purpose: lowest-numbered buffer selection from a request vector
// Assumes: request bits come from the same clock domain
// Notes:   purely combinational priority encoder
`timescale 1ns/1ps
module cmb_match
#(
    parameter NBUF = 16
)
(
    input  wire [NBUF-1:0] req,
    output reg             hit,
    output reg  [3:0]      idx
);
    integer i;
    // lowest entry wins, scanning downward keeps the last assignment
    always @*
    begin
        hit = 1'b0;
        idx = 4'h0;
        for (i = NBUF - 1; i >= 0; i = i - 1)
        begin
            if (req[i])
            begin
                hit = 1'b1;
                idx = i[3:0];
            end
        end
    end
endmodule // cmb_match

// File: hdl/cmb_handler.v
// Purpose: message buffer handling for a CAN controller
// Assumes: frame engine delivers pulses on clk, registers via plain port
// Notes:   one serial buffer for receive, one for transmit
`timescale 1ns/1ps
`include "cmb_regs.vh"
module cmb_handler
#(
    parameter NBUF = `CMB_NBUF
)
(
    input  wire        clk,
    input  wire        arst_n,
    input  wire [11:0] regAddr,
    input  wire [31:0] regWdata,
    input  wire        regWr,
    input  wire        regRd,
    output reg  [31:0] regRdata,
    input  wire        rxValid,
    input  wire        rxRemote,
    input  wire [31:0] rxId,
    input  wire [63:0] rxData,
    input  wire [3:0]  rxLen,
    input  wire [15:0] idStamp,
    input  wire        txSlotFree,
    input  wire        txDone,
    output reg         txReq,
    output reg  [31:0] txId,
    output reg  [63:0] txData,
    output reg  [3:0]  txLen,
    output reg         txRemote,
    input  wire        busDominant,
    input  wire [1:0]  busField,
    input  wire [3:0]  busBitIdx,
    input  wire        busRxFrame,
    output reg         overloadStart
);
    // per-buffer storage
    reg [3:0]  code   [0:NBUF-1];
    reg [15:0] stamp  [0:NBUF-1];
    reg [3:0]  bufLen [0:NBUF-1];
    reg        bufRtr [0:NBUF-1];
    reg [31:0] bufId  [0:NBUF-1];
    reg [31:0] dataHi [0:NBUF-1];
    reg [31:0] dataLo [0:NBUF-1];
    reg [NBUF-1:0] buffer_event_flags;
    reg [15:0] freeTimer;
    reg        lockValid;
    reg [3:0]  lockIdx;
    // receive serial buffer
    reg        srxFull;
    reg [31:0] srxId;
    reg [63:0] srxData;
    reg [3:0]  srxLen;
    reg [15:0] srxStamp;
    // copy engine (receive) and transmit slot state
    reg        copyBusy;
    reg [3:0]  copyIdx;
    reg [3:0]  copyCnt;
    reg        copyOvr;
    reg        txLoading;
    reg        txOwned;
    reg [3:0]  txIdx;
    reg        txCancelled;
    reg [NBUF-1:0] respPend;

    // address decode helpers
    function isBuf;
        input [11:0] a;
        begin
            isBuf = (a[11:8] == 4'h0);
        end
    endfunction
    function isCs;
        input [11:0] a;
        begin
            isCs = isBuf(a) && (a[3:0] == `CMB_OFS_CS);
        end
    endfunction

    wire [3:0] accIdx = regAddr[7:`CMB_BUF_SHIFT];
    wire csWr   = regWr && isCs(regAddr);
    wire csRd   = regRd && isCs(regAddr);
    wire dataWr = regWr && isBuf(regAddr) && !isCs(regAddr);
    wire timRd  = regRd && (regAddr == `CMB_ADDR_TIMER);
    wire flagWr = regWr && (regAddr == `CMB_ADDR_FLAGS);
    wire csBusy = copyBusy && (copyIdx == accIdx);

    // candidate vectors for matching and arbitration
    reg [NBUF-1:0] rxCand;
    reg [NBUF-1:0] remCand;
    reg [NBUF-1:0] txCand;
    integer k;
    always @*
    begin
        rxCand  = {NBUF{1'b0}};
        remCand = {NBUF{1'b0}};
        txCand  = {NBUF{1'b0}};
        for (k = 0; k < NBUF; k = k + 1)
        begin
            // active receivers compare id
            rxCand[k] = (code[k] == `CMB_CODE_RX_EMPTY ||
                         code[k] == `CMB_CODE_RX_FULL ||
                         code[k] == `CMB_CODE_RX_OVRN) &&
                        (bufId[k] == srxId) &&
                        !(csWr && accIdx == k[3:0]);
            // remote match exact, masks unused
            remCand[k] = (code[k] == `CMB_CODE_TX_RESP) &&
                         (bufId[k] == rxId);
            // write to control word withdraws candidate now
            txCand[k] = (code[k] == `CMB_CODE_TX_ONCE || respPend[k]) &&
                        !(csWr && accIdx == k[3:0]);
        end
    end

    wire       rxHit;
    wire [3:0] rxIdx;
    wire       txHit;
    wire [3:0] txSel;
    wire       remHit;
    wire [3:0] remIdx;
    // lowest-entry selection for receive
    cmb_match #(.NBUF(NBUF)) uRx
    (
        .req (rxCand),
        .hit (rxHit),
        .idx (rxIdx)
    );
    // lowest-entry arbitration; deactivated loser may be skipped
    cmb_match #(.NBUF(NBUF)) uTx
    (
        .req (txCand),
        .hit (txHit),
        .idx (txSel)
    );
    cmb_match #(.NBUF(NBUF)) uRem
    (
        .req (remCand),
        .hit (remHit),
        .idx (remIdx)
    );

    // target locked: frame parks in serial buffer
    wire rxBlocked = lockValid && (lockIdx == rxIdx);
    wire startCopy = srxFull && !copyBusy && rxHit && !rxBlocked;

    // free-running timer
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            freeTimer <= 16'h0000;
        else
            freeTimer <= freeTimer + 16'h0001;
    end

    // lock tracking; busy read does not lock
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            lockValid <= 1'b0;
            lockIdx   <= 4'h0;
        end
        else if (timRd)
            lockValid <= 1'b0;
        else if (csRd)
        begin
            lockValid <= !csBusy;
            lockIdx   <= accIdx;
        end
    end

    // receive serial buffer; newer frame overwrites parked one
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            srxFull  <= 1'b0;
            srxId    <= 32'h00000000;
            srxData  <= 64'h0000000000000000;
            srxLen   <= 4'h0;
            srxStamp <= 16'h0000;
        end
        else if (rxValid && !rxRemote)
        begin
            // own frames arrive here too remotes skip
            srxFull  <= 1'b1;
            srxId    <= rxId;
            srxData  <= rxData;
            srxLen   <= rxLen;
            srxStamp <= idStamp;
        end
        else if (startCopy || (srxFull && !rxHit))
            srxFull <= 1'b0; // unmatched frames are dropped
    end

    // register writes, copy engine and transmit slot
    integer n;
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (n = 0; n < NBUF; n = n + 1)
            begin
                code[n]   <= `CMB_CODE_RX_INACT;
                stamp[n]  <= 16'h0000;
                bufLen[n] <= 4'h0;
                bufRtr[n] <= 1'b0;
                bufId[n]  <= 32'h00000000;
                dataHi[n] <= 32'h00000000;
                dataLo[n] <= 32'h00000000;
            end
            buffer_event_flags <= {NBUF{1'b0}};
            copyBusy    <= 1'b0;
            copyIdx     <= 4'h0;
            copyCnt     <= 4'h0;
            copyOvr     <= 1'b0;
            txLoading   <= 1'b0;
            txOwned     <= 1'b0;
            txIdx       <= 4'h0;
            txCancelled <= 1'b0;
            respPend    <= {NBUF{1'b0}};
            txReq       <= 1'b0;
            txId        <= 32'h00000000;
            txData      <= 64'h0000000000000000;
            txLen       <= 4'h0;
            txRemote    <= 1'b0;
        end
        else
        begin
            // software clear of event flags; new event wins below
            if (flagWr)
                buffer_event_flags <= buffer_event_flags & regWdata[NBUF-1:0];
            if (regWr && isBuf(regAddr))
            begin
                case (regAddr[3:0])
                    `CMB_OFS_CS:
                    begin
                        code[accIdx]   <= regWdata[`CMB_CS_CODE_LSB+3:
                                                   `CMB_CS_CODE_LSB];
                        bufRtr[accIdx] <= regWdata[`CMB_CS_RTR_BIT];
                        bufLen[accIdx] <= regWdata[3:0];
                        respPend[accIdx] <= 1'b0;
                    end
                    `CMB_OFS_IDU:
                        bufId[accIdx] <= regWdata;
                    `CMB_OFS_IDL:
                        dataHi[accIdx] <= regWdata;
                    default:
                        dataLo[accIdx] <= regWdata;
                endcase
            end
            // remote frame starts a response
            if (rxValid && rxRemote && remHit)
                respPend[remIdx] <= 1'b1;
            // receive copy engine
            if (startCopy)
            begin
                copyBusy <= 1'b1;
                copyIdx  <= rxIdx;
                copyCnt  <= `CMB_COPY_CYCLES;
                copyOvr  <= (code[rxIdx] != `CMB_CODE_RX_EMPTY);
            end
            else if (copyBusy)
            begin
                if (csWr && accIdx == copyIdx)
                    copyBusy <= 1'b0; // halted, no flag
                else if (dataWr && accIdx == copyIdx)
                begin
                    // software data write mid-copy shows overrun
                    copyBusy     <= 1'b0;
                    code[copyIdx] <= `CMB_CODE_RX_OVRN;
                end
                else if (copyCnt != 4'h0)
                    copyCnt <= copyCnt - 4'h1;
                else
                begin
                    copyBusy         <= 1'b0;
                    bufId[copyIdx]   <= srxId;
                    dataHi[copyIdx]  <= srxData[63:32];
                    dataLo[copyIdx]  <= srxData[31:0];
                    bufLen[copyIdx]  <= srxLen;
                    stamp[copyIdx]   <= srxStamp;
                    code[copyIdx]    <= copyOvr ? `CMB_CODE_RX_OVRN :
                                                  `CMB_CODE_RX_FULL;
                    buffer_event_flags[copyIdx] <= 1'b1;
                end
            end
            // transmit: select, copy one cycle, then own the slot
            if (!txLoading && !txOwned && txSlotFree && txHit)
            begin
                txLoading <= 1'b1;
                txIdx     <= txSel;
            end
            else if (txLoading)
            begin
                txLoading <= 1'b0;
                if (!(csWr && accIdx == txIdx))
                begin
                    txOwned     <= 1'b1; // deactivation here drops it
                    txCancelled <= 1'b0;
                    txReq       <= 1'b1;
                    txId        <= bufId[txIdx];
                    txData      <= {dataHi[txIdx], dataLo[txIdx]};
                    txLen       <= (bufLen[txIdx] > 4'h8) ? 4'h8 :
                                                            bufLen[txIdx];
                    txRemote    <= bufRtr[txIdx];
                    respPend[txIdx] <= 1'b0;
                end
            end
            else if (txOwned)
            begin
                if (csWr && accIdx == txIdx)
                    txCancelled <= 1'b1; // still sent, no update
                if (txDone)
                begin
                    txOwned <= 1'b0;
                    txReq   <= 1'b0;
                    if (!txCancelled && !(csWr && accIdx == txIdx))
                    begin
                        stamp[txIdx] <= idStamp;
                        buffer_event_flags[txIdx] <= 1'b1;
                        if (bufRtr[txIdx] &&
                            code[txIdx] == `CMB_CODE_TX_ONCE)
                            code[txIdx] <= `CMB_CODE_RX_EMPTY;
                        else if (code[txIdx] == `CMB_CODE_TX_ONCE)
                            code[txIdx] <= `CMB_CODE_TX_INACT;
                    end
                end
            end
        end
    end

    // overload start only at the listed bit positions
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            overloadStart <= 1'b0;
        else
            case (busField)
                2'b00: overloadStart <= busDominant &&
                                        busBitIdx < 4'h2;
                2'b01: overloadStart <= busDominant && busRxFrame &&
                                        busBitIdx == `CMB_OVL_EOF_BIT;
                2'b10: overloadStart <= busDominant &&
                                        busBitIdx == `CMB_OVL_DLM_BIT;
                default: overloadStart <= 1'b0;
            endcase
    end

    // read data one cycle later; busy code forced during copy
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            regRdata <= 32'h00000000;
        else if (!regRd)
            regRdata <= 32'h00000000;
        else if (isBuf(regAddr))
            case (regAddr[3:0])
                `CMB_OFS_CS:
                    regRdata <= {4'h0,
                                 csBusy ? (code[accIdx] | 4'h1)
                                        : code[accIdx],
                                 stamp[accIdx], 3'h0,
                                 bufRtr[accIdx], bufLen[accIdx]};
                `CMB_OFS_IDU: regRdata <= bufId[accIdx];
                `CMB_OFS_IDL: regRdata <= dataHi[accIdx];
                default:      regRdata <= dataLo[accIdx];
            endcase
        else if (regAddr == `CMB_ADDR_FLAGS)
            regRdata <= {{(32-NBUF){1'b0}}, buffer_event_flags};
        else if (regAddr == `CMB_ADDR_TIMER)
            regRdata <= {16'h0000, freeTimer};
        else if (regAddr == `CMB_ADDR_STATUS)
            regRdata <= {22'h000000, srxFull, copyBusy, txOwned,
                         lockValid, 2'h0, lockIdx};
        else
            regRdata <= 32'h00000000;
    end
endmodule // cmb_handler

// File: verif/cmb_handler_assertions.sv
// Purpose: port-level checks for the message buffer handler
// Assumes: single clock domain, async active-low reset
// Notes:   bound to every cmb_handler instance below
`timescale 1ns/1ps
module cmb_handler_assertions
#(
    parameter NBUF = 16
)
(
    input wire        clk,
    input wire        arst_n,
    input wire [11:0] regAddr,
    input wire        regRd,
    input wire [31:0] regRdata,
    input wire        txSlotFree,
    input wire        txDone,
    input wire        txReq,
    input wire [31:0] txId,
    input wire [63:0] txData,
    input wire [3:0]  txLen,
    input wire        txRemote,
    input wire        busDominant,
    input wire [1:0]  busField,
    input wire [3:0]  busBitIdx,
    input wire        busRxFrame,
    input wire        overloadStart
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // the only bit times at which an overload may begin
    wire ovlCause = busDominant && ((busField == 2'h0 && busBitIdx < 4'h2)
        || (busField == 2'h1 && busBitIdx == 4'h6 && busRxFrame)
        || (busField == 2'h2 && busBitIdx == 4'h7));

    a_rdata_idle: assert property (
        !$past(regRd) |-> regRdata == 32'h0) else $error("read data not idle");
    a_unmapped_zero: assert property (
        regRd && regAddr == 12'h200 |=> regRdata == 32'h0)
        else $error("unmapped read not zero");
    a_req_holds: assert property (
        txReq && !txDone |=> txReq) else $error("tx request withdrawn");
    a_frame_stable: assert property (
        txReq && !txDone |=> $stable({txId, txData, txLen, txRemote}))
        else $error("tx frame changed while pending");
    a_req_drops: assert property (
        txReq && txDone |=> !txReq) else $error("tx request kept after done");
    a_load_slot: assert property (
        $rose(txReq) |-> $past(txSlotFree) || $past(txSlotFree, 2))
        else $error("tx loaded without free slot");
    a_ovl_cause: assert property (
        overloadStart |-> $past(ovlCause)) else $error("overload without cause");
    a_reset_quiet: assert property (
        $rose(arst_n) |-> !txReq && !overloadStart && regRdata == 32'h0)
        else $error("outputs active after reset");

    c_tx_done: cover property (txReq && txDone);
    c_overload: cover property (overloadStart);
    c_read_data: cover property (regRd ##1 regRdata != 32'h0);
endmodule // cmb_handler_assertions

bind cmb_handler cmb_handler_assertions #(.NBUF(NBUF)) i_cmb_handler_assertions (
    .clk, .arst_n, .regAddr, .regRd, .regRdata, .txSlotFree, .txDone, .txReq,
    .txId, .txData, .txLen, .txRemote, .busDominant, .busField, .busBitIdx,
    .busRxFrame, .overloadStart);

// File: verif/cmb_far_node.sv
// Purpose: far-side frame engine answering transmit requests
// Assumes: txReq level held until txDone
// Notes:   stall keeps the serial slot busy, delay sets answer speed
`timescale 1ns/1ps
module cmb_far_node
(
    input  wire       clk,
    input  wire       arst_n,
    input  wire       txReq,
    input  wire       stall,
    input  wire [3:0] delay,
    output reg        txSlotFree,
    output reg        txDone
);
    reg [3:0] cnt;

    // slot is busy while a frame is on the wire or bus is stalled
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt        <= 4'h0;
            txDone     <= 1'b0;
            txSlotFree <= 1'b0;
        end
        else
        begin
            txDone     <= 1'b0;
            txSlotFree <= !txReq && !stall && !txDone;
            if (txReq && !txDone)
            begin
                cnt <= cnt + 4'h1;
                if (cnt >= delay) // one pulse per frame
                begin
                    txDone <= 1'b1;
                    cnt    <= 4'h0;
                end
            end
        end
    end
endmodule // cmb_far_node

// File: verif/cmb_handler_test.sv
// Purpose: self-checking bench for the message buffer handler
// Assumes: frame engine transmit side modelled by cmb_far_node
// Notes:   expected flags kept in a small bench model
`timescale 1ns/1ps
`include "cmb_regs.vh"
module cmb_handler_test;
    localparam [31:0] IDA = 32'h0ABC0000;
    localparam [31:0] IDT = 32'h05550000;
    localparam [31:0] IDQ = 32'h07770000;
    localparam [31:0] RXE = {4'h0, `CMB_CODE_RX_EMPTY, 24'h0};
    localparam [31:0] TXO = {4'h0, `CMB_CODE_TX_ONCE, 24'h0};
    reg         clk;
    reg         arst_n;
    reg  [11:0] regAddr;
    reg  [31:0] regWdata;
    reg         regWr;
    reg         regRd;
    wire [31:0] regRdata;
    reg         rxValid;
    reg         rxRemote;
    reg  [31:0] rxId;
    reg  [63:0] rxData;
    reg  [3:0]  rxLen;
    reg  [15:0] idStamp;
    wire        txSlotFree;
    wire        txDone;
    wire        txReq;
    wire [31:0] txId;
    wire [63:0] txData;
    wire [3:0]  txLen;
    wire        txRemote;
    reg         busDominant;
    reg  [1:0]  busField;
    reg  [3:0]  busBitIdx;
    reg         busRxFrame;
    wire        overloadStart;
    reg         stall;
    reg  [3:0]  delay;
    integer     seed;
    integer     n_mismatch;
    integer     checks;
    integer     mflags;
    integer     i;
    reg  [31:0] d;
    reg  [31:0] v;
    reg         e;

    cmb_handler #(.NBUF(16)) i_cmb_handler (.clk, .arst_n, .regAddr,
        .regWdata, .regWr, .regRd, .regRdata, .rxValid, .rxRemote, .rxId,
        .rxData, .rxLen, .idStamp, .txSlotFree, .txDone, .txReq, .txId,
        .txData, .txLen, .txRemote, .busDominant, .busField, .busBitIdx,
        .busRxFrame, .overloadStart);
    cmb_far_node i_cmb_far_node (.clk, .arst_n, .txReq, .stall, .delay,
        .txSlotFree, .txDone);

    task stop_test;
    begin
        if (n_mismatch == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    end
    endtask

    task chk(input [63:0] nm, input [31:0] ex, input [31:0] got);
    begin
        checks = checks + 1;
        if (got !== ex)
        begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0s exp %h got %h", nm, ex, got);
        end
    end
    endtask

    task wr(input [11:0] a, input [31:0] w);
    begin
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= w;
        @(posedge clk);
        regWr    <= 1'b0;
    end
    endtask

    // read data stands only in the cycle after the strobe
    task rd(input [11:0] a);
    begin
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd   <= 1'b0;
        #1 d = regRdata;
    end
    endtask

    task send(input [31:0] id, input rem, input [15:0] st);
    begin
        @(posedge clk);
        rxValid  <= 1'b1;
        rxRemote <= rem;
        rxId     <= id;
        idStamp  <= st;
        rxData   <= {$random(seed), $random(seed)};
        @(posedge clk);
        rxValid  <= 1'b0;
        rxRemote <= 1'b0;
    end
    endtask

    // deactivate, ids, data for tx only, then activate
    task prep(input [3:0] n, input [31:0] id, input [31:0] ctl);
    begin
        wr({4'h0, n, `CMB_OFS_CS}, {4'h0, ctl[27:24] & 4'h8, 24'h0});
        wr({4'h0, n, `CMB_OFS_IDU}, id);
        wr({4'h0, n, `CMB_OFS_IDL}, 32'h0);
        if (ctl[27])
            wr({4'h0, n, `CMB_OFS_DATA}, $random(seed));
        wr({4'h0, n, `CMB_OFS_CS}, ctl);
    end
    endtask

    task wait_req(input want);
    begin
        i = 0;
        while (txReq !== want && i < 300)
        begin
            @(posedge clk);
            i = i + 1;
        end
        if (txReq !== want)
        begin
            n_mismatch = n_mismatch + 1;
            stop_test;
        end
    end
    endtask

    task txrun(input [31:0] id, input rem, input [3:0] len);
    begin
        v = $random(seed);
        delay <= 4'h1 + v[2:0];
        wait_req(1'b1);
        chk("txId", id, txId);
        chk("txRemote", {31'h0, rem}, {31'h0, txRemote});
        chk("txLen", {28'h0, len}, {28'h0, txLen});
        wait_req(1'b0);
    end
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // hang guard
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        stop_test;
    end

    initial
    begin
        seed = 32'h148a950a;
        n_mismatch = 0;
        checks = 0;
        {arst_n, regAddr, regWdata, regWr, regRd, rxValid, rxRemote} = 0;
        {rxId, rxData, rxLen, idStamp, busDominant, busField} = 0;
        {busBitIdx, busRxFrame, stall} = 0;
        delay = 4'h2;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        rd(`CMB_ADDR_FLAGS);
        chk("flags", 0, d);
        rd(12'h200);
        chk("unmapped", 0, d);
        // two receivers share one id, lowest takes the frame
        prep(4'h2, IDA, RXE);
        prep(4'h5, IDA, RXE);
        send(IDA, 1'b0, 16'h1234);
        repeat (10) @(posedge clk);
        mflags = 1 << 2;
        rd(`CMB_ADDR_FLAGS);
        chk("flags", mflags, d);
        rd(12'h020);
        chk("code", `CMB_CODE_RX_FULL, d[27:24]);
        chk("stamp", 16'h1234, d[23:8]);
        // buffer 2 is now locked; deactivate buffer 5 so frames park
        wr(12'h050, 32'h0);
        wr(`CMB_ADDR_FLAGS, 32'h0);
        send(IDA, 1'b0, 16'h1111);
        send(IDA, 1'b0, 16'h2222);
        repeat (10) @(posedge clk);
        rd(`CMB_ADDR_FLAGS);
        chk("flags", 0, d);
        rd(`CMB_ADDR_TIMER);
        repeat (10) @(posedge clk);
        rd(`CMB_ADDR_FLAGS);
        chk("flags", mflags, d);
        rd(12'h020);
        chk("stamp", 16'h2222, d[23:8]);
        rd(`CMB_ADDR_TIMER);
        wr(`CMB_ADDR_FLAGS, 32'h0);
        send(IDA, 1'b0, 16'h3333);
        rd(12'h020);
        chk("busy", 1, d[24]);
        repeat (10) @(posedge clk);
        rd(`CMB_ADDR_FLAGS);
        chk("flags", mflags, d);
        rd(`CMB_ADDR_TIMER);
        // single transmit, then remote request turning into receiver
        wr(`CMB_ADDR_FLAGS, 32'h0);
        prep(4'h7, IDT, TXO | 32'h8);
        txrun(IDT, 1'b0, 4'h8);
        rd(`CMB_ADDR_FLAGS);
        chk("flags", 1 << 7, d);
        rd(12'h070);
        chk("code", `CMB_CODE_TX_INACT, d[27:24]);
        chk("stamp", 16'h3333, d[23:8]);
        prep(4'h9, IDQ, TXO | 32'h10);
        txrun(IDQ, 1'b1, 4'h0);
        rd(12'h090);
        chk("code", `CMB_CODE_RX_EMPTY, d[27:24]);
        // data write while a frame lands in buffer 9 forces overrun
        rd(`CMB_ADDR_TIMER);
        send(IDQ, 1'b0, 16'h5555);
        wr(12'h09C, 32'h0);
        rd(12'h090);
        chk("code", `CMB_CODE_RX_OVRN, d[27:24]);
        // remote frame: answered by buffer 11, never stored in 9
        prep(4'hB, IDQ, {4'h0, `CMB_CODE_TX_RESP, 24'h2});
        wr(`CMB_ADDR_FLAGS, 32'h0);
        send(IDQ, 1'b1, 16'h4444);
        txrun(IDQ, 1'b0, 4'h2);
        rd(`CMB_ADDR_FLAGS);
        chk("flags", 1 << 11, d);
        // deactivate a pending buffer while the slot is held busy
        stall <= 1'b1;
        prep(4'h7, IDT, TXO | 32'h8);
        wr(12'h070, {4'h0, `CMB_CODE_TX_INACT, 24'h0});
        stall <= 1'b0;
        e = 1'b0;
        repeat (30)
        begin
            @(posedge clk);
            e = e | txReq;
        end
        chk("txReq", 0, {31'h0, e});
        // random bit-time qualifiers against the overload rule
        repeat (300)
        begin
            @(posedge clk);
            v = $random(seed);
            e = busDominant && ((busField == 2'h0 && busBitIdx < 4'h2)
                || (busField == 2'h1 && busBitIdx == 4'h6 && busRxFrame)
                || (busField == 2'h2 && busBitIdx == 4'h7));
            busBitIdx   <= {1'b0, v[2:0]};
            busField    <= v[4:3];
            busDominant <= v[5];
            busRxFrame  <= v[6];
            #1;
            chk("overload", {31'h0, e}, {31'h0, overloadStart});
        end
        stop_test;
    end
endmodule // cmb_handler_test
